/* File: core/vwm_pkg.sv */
package vwm_pkg;
    // Register byte offsets on the Avalon slave
    localparam logic [5:0] OFS_WIN_CTRL = 6'h00;
    localparam logic [5:0] OFS_AUX_CTRL = 6'h04;
    localparam logic [5:0] OFS_HZOOM = 6'h08;
    localparam logic [5:0] OFS_VZOOM = 6'h0c;
    localparam logic [5:0] OFS_KEY_MODE = 6'h10;
    localparam logic [5:0] OFS_KEY_BASE = 6'h14;
    localparam logic [5:0] KEY_STRIDE = 6'h04;
    localparam logic [5:0] OFS_LUMA = 6'h2c;
    localparam logic [5:0] OFS_GFX_CFG = 6'h30;
    localparam logic [5:0] OFS_PAL_IDX = 6'h34;
    localparam logic [5:0] OFS_PAL_DATA = 6'h38;
    localparam logic [5:0] OFS_STATUS = 6'h3c;
    localparam int KEY_REGS = 6;
    // Field positions
    localparam int WIN_EN_BIT = 0;
    localparam int FMT_LSB = 1;
    localparam int FMT_MSB = 3;
    localparam int LREP_BIT = 4;
    localparam int OCCL_BIT = 7;
    localparam int PLANAR_BIT = 4;
    localparam int CMP_LSB = 3;
    localparam int CMP_MSB = 4;
    localparam int KEYSRC_BIT = 5;
    localparam int DBL_BIT = 2;
    localparam int PAL_W = 18;
    localparam int PAL_DEPTH = 256;
    // Reset value shared by all control registers
    localparam logic [7:0] REG_RST = 8'h00;
    // Video display formats
    localparam logic [2:0] FMT_YUV422 = 3'h0;
    localparam logic [2:0] FMT_PACKED = 3'h1;
    localparam logic [2:0] FMT_PAL = 3'h2;
    localparam logic [2:0] FMT_RGB555 = 3'h4;
    localparam logic [2:0] FMT_RGB565 = 3'h5;
    // Color key compare modes
    localparam logic [1:0] CMP_MASK8 = 2'h0;
    localparam logic [1:0] CMP_FULL16 = 2'h1;
    localparam logic [1:0] CMP_TOP_BIT = 2'h3;
    // Graphics formats
    localparam logic [1:0] GFX_8BIT = 2'h0;
    localparam logic [1:0] GFX_RGB16 = 2'h1;
    localparam logic [1:0] GFX_PACKED24 = 2'h2;
    localparam logic [1:0] GFX_ARGB32 = 2'h3;
    // Interpolation weights and window granularity masks
    localparam logic [2:0] W_FULL = 3'h4;
    localparam logic [8:0] W_ROUND = 9'h020;
    localparam int W_SHIFT = 6;
    localparam logic [1:0] GRAN4 = 2'h3;
    localparam logic [1:0] GRAN2 = 2'h1;
endpackage

/* File: core/video_window_mixer.sv */
`timescale 1ns/1ns
// Functional notes
// RULE1: Decode 3-bit display format; codes 011, 110, 111 are reserved.
// RULE2: Format 000 is interleaved YUYV, or planar assist when that flag is set.
// RULE3: Palette video uses 256x18 palette, only valid with 16-bit RGB graphics.
// RULE4: Format 100 enables bus video writes; with planar flag, RGB decimation.
// RULE5: Software never enables vertical interpolation together with occlusion.
// RULE6: Software never enables the window with 32-bit ARGB graphics.
// RULE7: Packed 24-bit graphics: no occlusion, window edges on 4-pixel multiples.
// RULE8: Doubled pixel clock: replicate each zoomed pixel, 2-pixel window granularity.
// RULE9: Zoom factor is 256 over the 8-bit code; code 0 means 1:1.
// RULE10: Horizontal zoom always interpolates with five discrete weights.
// RULE11: Vertical zoom replicates lines when the replicate bit is 1, else interpolates.
// RULE12: Software picks line replication whenever occlusion is enabled.
// RULE13: Occlusion enable mixes video and graphics per pixel, inside window only.
// RULE14: Key source bit: 0 keys on graphics color, 1 on video chroma ranges.
// RULE15: Color key match shows the video pixel, otherwise the graphics pixel.
// RULE16: Compare mode 00: 8-bit key compare, mask ones ignore key bits.
// RULE17: Compare mode 01: full 16-bit compare against high and low key bytes.
// RULE18: Compare mode 11: key high bit 7 against graphics pixel bit 15.
// RULE19: Chroma key compares three min/max pairs on decoded source before zoom.
// RULE20: All three components inclusively in range shows the graphics pixel.
// RULE21: Add 5-bit brightness offset to luminance of every YUV window pixel.
// RULE22: Format 001 expands four-byte packets to YUV 4:2:2, window only.
// RULE23: Window enable bit takes effect at the next vertical sync leading edge.
module video_window_mixer
    import vwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic vsync,
    input wire logic line_start,
    input wire logic pix_valid,
    input wire logic in_window,
    input wire logic [23:0] gfx_pixel,
    input wire logic [31:0] src_cur,
    input wire logic [31:0] src_nxt,
    input wire logic [31:0] src_cur_below,
    input wire logic [31:0] src_nxt_below,
    output logic src_advance,
    output logic line_advance,
    output logic out_valid,
    output logic [23:0] out_pixel,
    output logic out_is_video,
    output logic out_is_yuv,
    output logic pci_video_write_en,
    output logic rgb_decimate_en
);

////////////////////////////////////////////////////////////////////////////////
    // Decode one source pixel of a two-dword window into three 8-bit components
    function automatic logic [23:0] decode(input logic [2:0] f, input logic pl,
        input logic [63:0] w, input logic [2:0] pos, input logic [PAL_W-1:0] pe);
        logic [31:0] d;
        logic [7:0] b;
        logic [15:0] h;
        logic [23:0] r;
        b = w[{pos, 3'h0} +: 8];
        h = w[{pos[1:0], 4'h0} +: 16];
        d = ((f == FMT_PAL || f == FMT_PACKED) ? pos[2] : pos[1]) ? w[63:32] : w[31:0];
        case (f)
            FMT_YUV422: r = pl ? {d[{pos[0], 3'h0} +: 8], d[23:16], d[31:24]} // RULE2
                               : {h[7:0], d[15:8], d[31:24]}; // RULE2
            FMT_PACKED: r = {b[7:3], 3'h0, d[2:0], d[10:8], 2'h0, d[18:16], d[26:24], 2'h0}; // RULE22
            FMT_PAL: r = {pe[17:12], pe[17:16], pe[11:6], pe[11:10], pe[5:0], pe[5:4]}; // RULE3
            FMT_RGB555: r = {h[14:10], h[14:12], h[9:5], h[9:7], h[4:0], h[4:2]};
            FMT_RGB565: r = {h[15:11], h[15:13], h[10:5], h[10:9], h[4:0], h[4:2]};
            default: r = 24'h000000;
        endcase
        return r;
    endfunction

    // Weighted average of two pixels, weight in quarters of the second one
    function automatic logic [23:0] blend(input logic [23:0] p, input logic [23:0] q,
        input logic [2:0] wt);
        logic [10:0] s;
        logic [23:0] r;
        r = 24'h000000;
        for (int i = 0; i < 3; i++)
        begin
            s = 11'(p[8*i +: 8]) * 11'(W_FULL - wt) + 11'(q[8*i +: 8]) * 11'(wt);
            r[8*i +: 8] = s[9:2];
        end
        return r;
    endfunction

////////////////////////////////////////////////////////////////////////////////
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0] win_ctrl_ff;
    logic [7:0] aux_ctrl_ff;
    logic [7:0] hzoom_ff;
    logic [7:0] vzoom_ff;
    logic [7:0] key_mode_ff;
    logic [7:0] key_ff [KEY_REGS];
    logic [4:0] luma_ff;
    logic [2:0] gfx_cfg_ff;
    logic [7:0] pal_idx_ff;
    logic [PAL_W-1:0] palette [PAL_DEPTH];
    logic wr_go;
    logic vsync_q_ff;
    logic vs_rise;
    logic win_en_ff;
    logic [2:0] fmt;
    logic [1:0] gfx_fmt;
    logic fmt_rsv;
    logic pal_bad;
    logic vid_ok;
    logic occl_on;
    logic key_src;
    logic is_yuv;
    logic dbl;
    logic [1:0] hcnt_ff;
    logic [1:0] gran;
    logic vis;
    logic win_q_ff;
    logic vid_show;
    logic rep_ff;
    logic step_en;
    logic [7:0] hacc_ff;
    logic [8:0] hsum;
    logic adv;
    logic [2:0] hidx_ff;
    logic [2:0] hlast;
    logic [2:0] hw;
    logic [7:0] vacc_ff;
    logic [8:0] vsum;
    logic [2:0] vw;
    logic [63:0] w_top;
    logic [63:0] w_bot;
    logic [2:0] pos_b;
    logic [23:0] px_a;
    logic [23:0] px_b;
    logic [23:0] px_c;
    logic [23:0] px_d;
    logic [23:0] zoomed;
    logic [8:0] ysum;
    logic [23:0] vpix;
    logic chroma_in;
    logic ckey_hit;
    logic use_vid;
    logic out_valid_ff;
    logic [23:0] out_pixel_ff;
    logic out_is_video_ff;
    logic out_is_yuv_ff;
    logic pci_ff;
    logic dec_ff;

////////////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, read data and write effect at the release edge
    assign waitrequest = (read | write) & ~ack_ff;
    assign readdata = rdata_ff;
    assign wr_go = write & ack_ff & byteenable[0];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            ack_ff <= 1'b0;
        else
            ack_ff <= (read | write) & ~ack_ff;
    end

    // Read multiplexer; unmapped offsets read as zero
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        case (address)
            OFS_WIN_CTRL: nxt_rdata[7:0] = win_ctrl_ff;
            OFS_AUX_CTRL: nxt_rdata[7:0] = aux_ctrl_ff;
            OFS_HZOOM: nxt_rdata[7:0] = hzoom_ff;
            OFS_VZOOM: nxt_rdata[7:0] = vzoom_ff;
            OFS_KEY_MODE: nxt_rdata[7:0] = key_mode_ff;
            OFS_LUMA: nxt_rdata[4:0] = luma_ff;
            OFS_GFX_CFG: nxt_rdata[2:0] = gfx_cfg_ff;
            OFS_PAL_IDX: nxt_rdata[7:0] = pal_idx_ff;
            OFS_PAL_DATA: nxt_rdata[PAL_W-1:0] = palette[pal_idx_ff];
            OFS_STATUS: nxt_rdata[2:0] = {pal_bad, fmt_rsv, win_en_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
        for (int k = 0; k < KEY_REGS; k++)
        begin
            if (address == 6'(OFS_KEY_BASE + KEY_STRIDE * 6'(k)))
                nxt_rdata[7:0] = key_ff[k];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            rdata_ff <= 32'h00000000;
        else if (read & ~ack_ff)
            rdata_ff <= nxt_rdata;
    end

    // Control register writes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            win_ctrl_ff <= REG_RST;
            aux_ctrl_ff <= REG_RST;
            hzoom_ff <= REG_RST;
            vzoom_ff <= REG_RST;
            key_mode_ff <= REG_RST;
            luma_ff <= REG_RST[4:0];
            gfx_cfg_ff <= REG_RST[2:0];
            for (int k = 0; k < KEY_REGS; k++)
                key_ff[k] <= REG_RST;
        end
        else if (wr_go)
        begin
            case (address)
                OFS_WIN_CTRL: win_ctrl_ff <= writedata[7:0];
                OFS_AUX_CTRL: aux_ctrl_ff <= writedata[7:0];
                OFS_HZOOM: hzoom_ff <= writedata[7:0];
                OFS_VZOOM: vzoom_ff <= writedata[7:0];
                OFS_KEY_MODE: key_mode_ff <= writedata[7:0];
                OFS_LUMA: luma_ff <= writedata[4:0];
                OFS_GFX_CFG: gfx_cfg_ff <= writedata[2:0];
                default: ;
            endcase
            for (int k = 0; k < KEY_REGS; k++)
            begin
                if (address == 6'(OFS_KEY_BASE + KEY_STRIDE * 6'(k)))
                    key_ff[k] <= writedata[7:0];
            end
        end
    end

    // Palette index auto-increments after each data write that enables byte lanes 0 to 2
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            pal_idx_ff <= REG_RST;
        else if (wr_go && address == OFS_PAL_IDX)
            pal_idx_ff <= writedata[7:0];
        else if (wr_go && address == OFS_PAL_DATA && (&byteenable[2:0]))
            pal_idx_ff <= pal_idx_ff + 8'h01;
    end

    // Palette storage, not reset
    always_ff @(posedge clk_sys)
    begin
        if (wr_go && address == OFS_PAL_DATA && (&byteenable[2:0]))
            palette[pal_idx_ff] <= writedata[PAL_W-1:0]; // RULE3
    end

////////////////////////////////////////////////////////////////////////////////
    // Window enable is shadowed until the vertical sync leading edge
    assign vs_rise = vsync & ~vsync_q_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            vsync_q_ff <= 1'b0;
            win_en_ff <= 1'b0;
        end
        else
        begin
            vsync_q_ff <= vsync;
            if (vs_rise)
                win_en_ff <= win_ctrl_ff[WIN_EN_BIT]; // RULE23
        end
    end

    // Mode decode and legality of the video path
    assign fmt = win_ctrl_ff[FMT_MSB:FMT_LSB];
    assign gfx_fmt = gfx_cfg_ff[1:0];
    assign dbl = gfx_cfg_ff[DBL_BIT];
    assign key_src = key_mode_ff[KEYSRC_BIT]; // RULE14
    assign fmt_rsv = !(fmt inside {FMT_YUV422, FMT_PACKED, FMT_PAL, FMT_RGB555, FMT_RGB565}); // RULE1
    assign pal_bad = (fmt == FMT_PAL) && (gfx_fmt != GFX_RGB16); // RULE3
    assign vid_ok = win_en_ff & ~fmt_rsv & ~pal_bad & (gfx_fmt != GFX_ARGB32); // RULE6
    assign occl_on = win_ctrl_ff[OCCL_BIT] & (gfx_fmt != GFX_PACKED24); // RULE7
    assign is_yuv = (fmt == FMT_YUV422) || (fmt == FMT_PACKED);

    // Window edges only move on the granularity grid of the graphics mode
    assign gran = (gfx_fmt == GFX_PACKED24) ? GRAN4 : (dbl ? GRAN2 : 2'h0); // RULE7 RULE8
    assign vis = ((hcnt_ff & gran) == 2'h0) ? in_window : win_q_ff;
    assign vid_show = vid_ok & vis; // RULE22

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || line_start)
        begin
            hcnt_ff <= 2'h0;
            win_q_ff <= 1'b0;
        end
        else if (pix_valid)
        begin
            hcnt_ff <= hcnt_ff + 2'h1;
            win_q_ff <= vis;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Horizontal zoom: phase accumulator steps by the code, carry takes a new source pixel
    assign step_en = pix_valid & vid_show & (~dbl | rep_ff); // RULE8
    assign hsum = {1'b0, hacc_ff} + {1'b0, hzoom_ff};
    assign adv = step_en & ((hzoom_ff == 8'h00) | hsum[8]); // RULE9
    assign hlast = (fmt == FMT_PAL || fmt == FMT_PACKED) ? 3'h3 : 3'h1;
    assign src_advance = adv & (hidx_ff == hlast);
    assign hw = (hzoom_ff == 8'h00) ? 3'h0 : 3'(({1'b0, hacc_ff} + W_ROUND) >> W_SHIFT); // RULE10

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || line_start)
        begin
            rep_ff <= 1'b0;
            hacc_ff <= 8'h00;
            hidx_ff <= 3'h0;
        end
        else
        begin
            if (pix_valid & vid_show)
                rep_ff <= ~rep_ff; // RULE8
            if (step_en && hzoom_ff != 8'h00)
                hacc_ff <= hsum[7:0]; // RULE9
            if (adv)
                hidx_ff <= (hidx_ff == hlast) ? 3'h0 : hidx_ff + 3'h1;
        end
    end

    // Vertical zoom: per line accumulator, replication forces the weight to zero
    assign vsum = {1'b0, vacc_ff} + {1'b0, vzoom_ff};
    assign line_advance = line_start & win_en_ff & ((vzoom_ff == 8'h00) | vsum[8]); // RULE9
    assign vw = (win_ctrl_ff[LREP_BIT] || vzoom_ff == 8'h00) ? 3'h0
              : 3'(({1'b0, vacc_ff} + W_ROUND) >> W_SHIFT); // RULE11

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || vs_rise)
            vacc_ff <= 8'h00;
        else if (line_start && win_en_ff && vzoom_ff != 8'h00)
            vacc_ff <= vsum[7:0];
    end

////////////////////////////////////////////////////////////////////////////////
    // Decode the four neighbours, then interpolate vertically and horizontally
    assign w_top = {src_nxt, src_cur};
    assign w_bot = {src_nxt_below, src_cur_below};
    assign pos_b = hidx_ff + 3'h1;
    assign px_a = decode(fmt, aux_ctrl_ff[PLANAR_BIT], w_top, hidx_ff, palette[w_top[{hidx_ff, 3'h0} +: 8]]);
    assign px_b = decode(fmt, aux_ctrl_ff[PLANAR_BIT], w_top, pos_b, palette[w_top[{pos_b, 3'h0} +: 8]]);
    assign px_c = decode(fmt, aux_ctrl_ff[PLANAR_BIT], w_bot, hidx_ff, palette[w_bot[{hidx_ff, 3'h0} +: 8]]);
    assign px_d = decode(fmt, aux_ctrl_ff[PLANAR_BIT], w_bot, pos_b, palette[w_bot[{pos_b, 3'h0} +: 8]]);
    assign zoomed = blend(blend(px_a, px_c, vw), blend(px_b, px_d, vw), hw); // RULE10 RULE11

    // Brightness offset on luminance, saturating at full scale
    assign ysum = {1'b0, zoomed[23:16]} + 9'(luma_ff);
    assign vpix = is_yuv ? {(ysum[8] ? 8'hff : ysum[7:0]), zoomed[15:0]} : zoomed; // RULE21

    // Chroma range check on the decoded source pixel, bounds inclusive
    always_comb
    begin
        chroma_in = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            if (px_a[23-8*k -: 8] < key_ff[2*k] || px_a[23-8*k -: 8] > key_ff[2*k+1])
                chroma_in = 1'b0; // RULE19 RULE20
        end
    end

    // Graphics color key compare
    always_comb
    begin
        case (key_mode_ff[CMP_MSB:CMP_LSB])
            CMP_MASK8: ckey_hit = ((gfx_pixel[7:0] ^ key_ff[0]) & ~key_ff[1]) == 8'h00; // RULE16
            CMP_FULL16: ckey_hit = gfx_pixel[15:0] == {key_ff[1], key_ff[0]}; // RULE17
            CMP_TOP_BIT: ckey_hit = key_ff[1][7] == gfx_pixel[15]; // RULE18
            default: ckey_hit = 1'b0;
        endcase
    end

    // Pixel select inside the window
    assign use_vid = vid_show & (~occl_on | (key_src ? ~chroma_in : ckey_hit)); // RULE13 RULE15 RULE20

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            out_valid_ff <= 1'b0;
            out_pixel_ff <= 24'h000000;
            out_is_video_ff <= 1'b0;
            out_is_yuv_ff <= 1'b0;
        end
        else
        begin
            out_valid_ff <= pix_valid;
            if (pix_valid)
            begin
                out_pixel_ff <= use_vid ? vpix : gfx_pixel; // RULE15
                out_is_video_ff <= use_vid;
                out_is_yuv_ff <= use_vid & is_yuv;
            end
        end
    end

    // Aperture write paths selected by the RGB 5-5-5 format
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            pci_ff <= 1'b0;
            dec_ff <= 1'b0;
        end
        else
        begin
            pci_ff <= fmt == FMT_RGB555; // RULE4
            dec_ff <= (fmt == FMT_RGB555) & aux_ctrl_ff[PLANAR_BIT]; // RULE4
        end
    end

    assign out_valid = out_valid_ff;
    assign out_pixel = out_pixel_ff;
    assign out_is_video = out_is_video_ff;
    assign out_is_yuv = out_is_yuv_ff;
    assign pci_video_write_en = pci_ff;
    assign rgb_decimate_en = dec_ff;

////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_req_new;
        (read || write) && waitrequest;
    endsequence
    sequence s_ckey_pick;
        pix_valid && vid_show && occl_on && !key_src && ckey_hit;
    endsequence

    a_bus_one_wait: assert property (s_req_new |=> !waitrequest)
        else $error("Bus request not answered after one wait cycle");
    a_enable_at_vsync: assert property (!vs_rise |=> $stable(win_en_ff)) // RULE23
        else $error("Window enable changed without vsync edge");
    a_rsv_no_video: assert property ((pix_valid && fmt_rsv) |=> !out_is_video_ff) // RULE1
        else $error("Reserved format showed video");
    a_pal_needs_rgb16: assert property ((pix_valid && pal_bad) |=> !out_is_video_ff) // RULE3
        else $error("Palette video shown with wrong graphics format");
    a_pci_write_mode: assert property ((fmt == FMT_RGB555)[*2] |-> pci_ff) // RULE4
        else $error("Bus video write not enabled");
    a_no_occl_packed: assert property ((pix_valid && vid_show && gfx_fmt == GFX_PACKED24) |=> out_is_video_ff) // RULE7
        else $error("Occlusion active with packed 24-bit graphics");
    a_zoom_off_step: assert property ((step_en && hzoom_ff == 8'h00) |-> adv) // RULE9
        else $error("Zoom code zero did not advance source");
    a_zoom_hold_step: assert property ((step_en && hzoom_ff != 8'h00 && !hsum[8]) |-> !adv) // RULE9
        else $error("Source advanced without phase carry");
    a_line_repl: assert property (win_ctrl_ff[LREP_BIT] |-> vw == 3'h0) // RULE11
        else $error("Line replication used a vertical weight");
    a_ckey_video: assert property (s_ckey_pick |=> out_is_video_ff && out_pixel_ff == $past(vpix)) // RULE15
        else $error("Color key match did not show video");
    a_chroma_gfx: assert property ((pix_valid && vid_show && occl_on && key_src && chroma_in)
        |=> !out_is_video_ff && out_pixel_ff == $past(gfx_pixel)) // RULE20
        else $error("Chroma key hit did not show graphics");
endmodule

/* File: sim/src_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// Frame buffer fetch stand-in: a uniform field of one YUYV dword
module src_model
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic src_advance,
    input wire logic line_advance,
    output logic [31:0] src_cur,
    output logic [31:0] src_nxt,
    output logic [31:0] src_cur_below,
    output logic [31:0] src_nxt_below
);
    localparam logic [31:0] FILL = 32'h90406040;
    logic [9:0] dword_ff;
    logic [9:0] line_ff;
    // Fetch position, moved by the mixer's requests
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            dword_ff <= 10'h000;
            line_ff <= 10'h000;
        end
        else
        begin
            dword_ff <= line_advance ? 10'h000 : dword_ff + {9'h000, src_advance};
            line_ff <= line_ff + {9'h000, line_advance};
        end
    end
    // Uniform picture so every zoom phase sees the same colour
    assign src_cur = FILL;
    assign src_nxt = FILL;
    assign src_cur_below = FILL;
    assign src_nxt_below = FILL;
endmodule

/* File: sim/tb_video_window_mixer.sv */
`timescale 1ns/1ns
module tb_video_window_mixer
    import vwm_pkg::*;
;
    logic clk_sys, rst_b, read, write, waitrequest, vsync, line_start, pix_valid, in_window;
    logic src_advance, line_advance, out_valid, out_is_video, out_is_yuv, pci_video_write_en, rgb_decimate_en;
    logic [5:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, q, src_cur, src_nxt, src_cur_below, src_nxt_below;
    logic [23:0] gfx_pixel, out_pixel;
    logic ey;
    int errors, samples_checked, i;
    video_window_mixer video_window_mixer_inst (.clk_sys(clk_sys), .rst_b(rst_b), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .vsync(vsync), .line_start(line_start), .pix_valid(pix_valid),
        .in_window(in_window), .gfx_pixel(gfx_pixel), .src_cur(src_cur), .src_nxt(src_nxt),
        .src_cur_below(src_cur_below), .src_nxt_below(src_nxt_below), .src_advance(src_advance),
        .line_advance(line_advance), .out_valid(out_valid), .out_pixel(out_pixel),
        .out_is_video(out_is_video), .out_is_yuv(out_is_yuv), .pci_video_write_en(pci_video_write_en),
        .rgb_decimate_en(rgb_decimate_en));
    src_model src_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .src_advance(src_advance),
        .line_advance(line_advance), .src_cur(src_cur), .src_nxt(src_nxt),
        .src_cur_below(src_cur_below), .src_nxt_below(src_nxt_below));
    ////////////////////////////////////////////////////////////////////
    // Clock, verdict and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////
    // Bus, pixel and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        do
            @(posedge clk_sys);
        while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d}, 4'hf);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000, 4'h0);
        chk(q, exp);
    endtask
    // One pixel slot; the answer lands one cycle later
    task automatic px(input logic win, input logic [23:0] g, input logic [23:0] ep, input logic ev);
        @(posedge clk_sys);
        pix_valid <= 1'b1;
        in_window <= win;
        gfx_pixel <= g;
        @(posedge clk_sys);
        pix_valid <= 1'b0;
        #1;
        chk({7'h00, out_valid, out_pixel}, {8'h01, ep});
        chk({30'h0, out_is_yuv, out_is_video}, {30'h0, ev & ey, ev});
    endtask
    task automatic vs();
        @(posedge clk_sys);
        vsync <= 1'b1;
        @(posedge clk_sys);
        vsync <= 1'b0;
        @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence; interpolation never meets occlusion, no ARGB32 window
    initial
    begin
        {rst_b, read, write, vsync, line_start, pix_valid, in_window} = 7'h00;
        {address, byteenable, writedata, gfx_pixel} = '0;
        ey = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Palette is not reset: clear every entry, the index wraps back to zero
        for (i = 0; i < 256; i++) bus(1'b1, OFS_PAL_DATA, 32'h0, 4'h7);
        for (i = 0; i < 16; i++) rd(6'(i * 4), 32'h0);
        for (i = 2; i < 11; i++) wr(6'(i * 4), 8'(8'ha5 ^ i));
        for (i = 2; i < 11; i++) rd(6'(i * 4), {24'h0, 8'(8'ha5 ^ i)});
        bus(1'b1, OFS_HZOOM, 32'h77, 4'h0);
        rd(OFS_HZOOM, 32'ha7);
        wr(OFS_HZOOM, 8'h00);
        wr(OFS_GFX_CFG, 8'h01);
        wr(OFS_WIN_CTRL, 8'h91);
        wr(OFS_KEY_MODE, 8'h00);
        wr(OFS_KEY_BASE, 8'h34);
        wr(OFS_KEY_BASE + 6'h04, 8'h0f);
        wr(OFS_LUMA, 8'h10);
        @(posedge clk_sys);
        line_start <= 1'b1;
        @(posedge clk_sys);
        line_start <= 1'b0;
        rd(OFS_STATUS, 32'h0);
        px(1'b1, 24'h000037, 24'h000037, 1'b0);
        vs();
        rd(OFS_STATUS, 32'h1);
        px(1'b1, 24'h000037, 24'h506090, 1'b1);
        px(1'b1, 24'h000044, 24'h000044, 1'b0);
        px(1'b0, 24'h000037, 24'h000037, 1'b0);
        wr(OFS_KEY_MODE, 8'h08);
        wr(OFS_KEY_BASE + 6'h04, 8'h12);
        px(1'b1, 24'h001234, 24'h506090, 1'b1);
        px(1'b1, 24'h001235, 24'h001235, 1'b0);
        wr(OFS_KEY_MODE, 8'h18);
        wr(OFS_KEY_BASE + 6'h04, 8'h80);
        px(1'b1, 24'h008000, 24'h506090, 1'b1);
        px(1'b1, 24'h000000, 24'h000000, 1'b0);
        wr(OFS_KEY_MODE, 8'h20);
        for (i = 0; i < 6; i++) wr(OFS_KEY_BASE + 6'(i * 4), i < 2 ? 8'(8'h40 + i * 16) : i < 4 ? 8'h60 : 8'h90);
        px(1'b1, 24'h0000aa, 24'h0000aa, 1'b0);
        wr(OFS_KEY_BASE + 6'h08, 8'h61);
        px(1'b1, 24'h0000aa, 24'h506090, 1'b1);
        // Packed 24-bit graphics drops occlusion, so a chroma hit still shows video
        wr(OFS_KEY_BASE + 6'h08, 8'h60);
        wr(OFS_GFX_CFG, 8'h02);
        px(1'b1, 24'h0000aa, 24'h506090, 1'b1);
        wr(OFS_GFX_CFG, 8'h01);
        // RGB 5-6-5 video, second pixel of the dword, red outside its range
        wr(OFS_WIN_CTRL, 8'h9b);
        ey = 1'b0;
        px(1'b1, 24'h0000aa, 24'h940800, 1'b1);
        ey = 1'b1;
        wr(OFS_AUX_CTRL, 8'h10);
        wr(OFS_WIN_CTRL, 8'h09);
        @(posedge clk_sys);
        #1 chk({30'h0, pci_video_write_en, rgb_decimate_en}, 32'h3);
        wr(OFS_AUX_CTRL, 8'h00);
        wr(OFS_WIN_CTRL, 8'h01);
        @(posedge clk_sys);
        #1 chk({30'h0, pci_video_write_en, rgb_decimate_en}, 32'h0);
        for (i = 3; i < 8; i += (i == 3) ? 3 : 1)
        begin
            wr(OFS_WIN_CTRL, {4'h0, 3'(i), 1'b1});
            rd(OFS_STATUS, 32'h3);
            px(1'b1, 24'h000011, 24'h000011, 1'b0);
        end
        wr(OFS_GFX_CFG, 8'h00);
        wr(OFS_WIN_CTRL, 8'h05);
        rd(OFS_STATUS, 32'h5);
        // Fetch requests: five dwords at 1:1, then one new line with zoom code zero
        chk({12'h000, src_model_inst.line_ff, src_model_inst.dword_ff}, 32'h5);
        wr(OFS_VZOOM, 8'h00);
        @(posedge clk_sys);
        line_start <= 1'b1;
        @(posedge clk_sys);
        line_start <= 1'b0;
        #1 chk({12'h000, src_model_inst.line_ff, src_model_inst.dword_ff}, 32'h400);
        wr(OFS_WIN_CTRL, 8'h00);
        vs();
        rd(OFS_STATUS, 32'h0);
        wrap_up();
    end
endmodule
